// *** hw/pmvs_map.svh ***
// offsets, field positions, reset values and counts of the program memory access block
// Behaviour
// [R1] options live in nonvolatile cells, set before execution
// [R2] option bit 3 set disables watchdog reset
// [R3] programmer writes ones to option reserved bits
// [R4] signature read returns three fixed identity bytes
// [R5] lock blocks external table reads of internal code
// [R6] locked: access pin latched at reset, held
// [R7] lock state has no readable status bit
// [R8] mask variant: lock and table fixed at build
// [R9] verify output is stored byte XNOR table byte
// [R10] erased table passes true contents through verify
// [R11] verify: programmer sets address, device drives port 0
// [R12] rising quasi pin driven hard two cycles
// [R13] port 0 floats in reset and latched high
// [R14] port 0 bus mode holds last address weakly
// [R15] 64-byte table, programmable, never read back
// [R16] every verify read goes through the table
// [R17] programmer gives five or twenty-five strobes
// [R18] table byte chosen by low six address bits
`ifndef PMVS_MAP_SVH
`define PMVS_MAP_SVH

// register byte offsets on the slave bus
`define PMVS_OFF_CTRL 8'h00
`define PMVS_OFF_P0LATCH 8'h04
`define PMVS_OFF_P1LATCH 8'h08
`define PMVS_OFF_TBLADDR 8'h0C
`define PMVS_OFF_TBLDATA 8'h10
`define PMVS_OFF_STATUS 8'h14

// field positions
`define PMVS_CTRL_BUSMODE 0
`define PMVS_STAT_WDTAUTO 0
`define PMVS_STAT_BLOCKED 1
`define PMVS_OPT_WDTOFF 3

// programming addresses of the identity bytes
`define PMVS_SIG_ADDR_MFR 16'h0030
`define PMVS_SIG_ADDR_MODEL 16'h0031
`define PMVS_SIG_ADDR_EXT 16'h0060

// erased, reset and refused-read values
`define PMVS_ERASED 8'hFF
`define PMVS_LATCH_RST 8'hFF
`define PMVS_BLOCKED_DATA 8'hFF

// one-shot length, table size
`define PMVS_ONESHOT_CYCLES 2'h2
`define PMVS_ENC_DEPTH 64
`define PMVS_ENC_AW 6

`endif

// *** hw/pmvs_pkg.sv ***
// types shared by the program memory access block
package pmvs_pkg;

    // decoded programmer operation
    typedef enum logic [2:0] {
        PMVS_IDLE = 3'h0,
        PMVS_VERIFY = 3'h1,
        PMVS_SIGNATURE = 3'h3,
        PMVS_PROGRAM_STROBE_CODE = 3'h2,
        PMVS_PROGRAM_STROBE_ENC = 3'h6,
        PMVS_PROGRAM_STROBE_LOCK = 3'h7,
        PMVS_PROGRAM_STROBE_OPT = 3'h5
    } pmvs_mode_e;

    // programmer control pins in a bundle
    typedef struct packed {
        logic p26;
        logic p27;
        logic p33;
        logic p36;
        logic p37;
    } pmvs_ctl_s;

    // quasi-bidirectional port drive
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] strongEnN;
    } pmvs_quasi_s;

endpackage : pmvs_pkg

// *** hw/pmvs_core.sv ***
// program memory, option byte, lock, encrypted verify and port drive logic
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`include "pmvs_map.svh"

module pmvs_core #(
    parameter int ADDR_W = 14,
    parameter bit MASK_ROM = 1'b0,
    parameter bit LOCK_BUILT = 1'b0,
    parameter logic [7:0] ENC_BUILT = 8'hFF,
    parameter logic [7:0] SIG_MFR = 8'h5A, // arbitrary value
    parameter logic [7:0] SIG_MODEL = 8'h3C, // arbitrary value
    parameter logic [7:0] SIG_EXT = 8'h7E // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic eraseAll,
    input wire logic pgmEnable,
    input wire logic vppHigh,
    input wire pmvs_pkg::pmvs_ctl_s pgmCtl,
    input wire logic program_strobe_n,
    input wire logic [15:0] pgmAddr,
    input wire logic [7:0] p0In,
    output logic [7:0] p0Out,
    output logic [7:0] p0OeN,
    output logic p0WeakHold,
    input wire logic external_access_pin_n,
    input wire logic fetchExternal,
    input wire logic busDrive,
    input wire logic [7:0] busAddrLow,
    output pmvs_pkg::pmvs_quasi_s p1Drive,
    output logic wdtAutoEnable,
    output logic execExternal,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // nonvolatile cells: code array, table, option byte, lock
    logic [7:0] codeMem [0:(1<<ADDR_W)-1];
    logic [7:0] encMem [0:`PMVS_ENC_DEPTH-1];
    logic [7:0] option_r;
    logic lock_r;

    // volatile state
    logic eaLatch_r;
    logic strobePrev_r;
    logic busMode_r;
    logic [7:0] p0Latch_r;
    logic [7:0] p1Latch_r;
    logic [7:0] p1Prev_r;
    logic [ADDR_W-1:0] tblAddr_r;
    logic blocked_r;
    logic [1:0] shotCnt_r [0:7];
    logic [7:0] strongN_r;
    logic [7:0] p0Out_r;
    logic [7:0] p0OeN_r;
    logic p0Weak_r;
    logic wdtAuto_r;
    logic extExec_r;
    logic [31:0] rdata_r;
    logic wait_r;

    // decoded signals
    pmvs_pkg::pmvs_mode_e mode;
    logic strobeFall;
    logic lockEff;
    logic [ADDR_W-1:0] codeAddr;
    logic [`PMVS_ENC_AW-1:0] encIdx;
    logic busHit;
    logic tableBlocked;
    logic [7:0] verifyByte;

    // decode control pin levels into an operation
    function automatic pmvs_pkg::pmvs_mode_e decodeMode(input pmvs_pkg::pmvs_ctl_s c);
        unique case ({c.p26, c.p27, c.p33, c.p36, c.p37})
            5'h03: decodeMode = pmvs_pkg::PMVS_VERIFY;
            5'h00: decodeMode = pmvs_pkg::PMVS_SIGNATURE;
            5'h0F: decodeMode = pmvs_pkg::PMVS_PROGRAM_STROBE_CODE;
            5'h0D: decodeMode = pmvs_pkg::PMVS_PROGRAM_STROBE_ENC;
            5'h1F: decodeMode = pmvs_pkg::PMVS_PROGRAM_STROBE_LOCK;
            5'h0C: decodeMode = pmvs_pkg::PMVS_PROGRAM_STROBE_OPT;
            default: decodeMode = pmvs_pkg::PMVS_IDLE;
        endcase
    endfunction : decodeMode

    // identity byte for a programming address, zero elsewhere
    function automatic logic [7:0] sigByte(input logic [15:0] a);
        if (a == `PMVS_SIG_ADDR_MFR) begin
            sigByte = SIG_MFR; // [R4]
        end else if (a == `PMVS_SIG_ADDR_MODEL) begin
            sigByte = SIG_MODEL; // [R4]
        end else if (a == `PMVS_SIG_ADDR_EXT) begin
            sigByte = SIG_EXT; // [R4]
        end else begin
            sigByte = 8'h00;
        end
    endfunction : sigByte

    assign mode = pgmEnable ? decodeMode(pgmCtl) : pmvs_pkg::PMVS_IDLE;
    assign strobeFall = strobePrev_r & ~program_strobe_n;
    // mask variant lock is built in and cannot change
    assign lockEff = MASK_ROM ? LOCK_BUILT : lock_r; // [R8]
    assign codeAddr = pgmAddr[ADDR_W-1:0];
    // table index from low six address bits, table repeats
    assign encIdx = pgmAddr[`PMVS_ENC_AW-1:0]; // [R18]
    // stored byte XNOR table byte, erased table passes data
    assign verifyByte = ~(codeMem[codeAddr] ^ encMem[encIdx]); // [R9] [R10] [R16]
    assign busHit = avs_read | avs_write;
    // locked device refuses table reads from external code
    assign tableBlocked = lockEff & fetchExternal; // [R5]

    // strobe edge tracker
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strobePrev_r <= 1'b1;
        end else begin
            strobePrev_r <= program_strobe_n;
        end
    end

    // code array writes, one write per strobe fall, none on mask variant
    always_ff @(posedge mclk) begin
        if (!MASK_ROM && strobeFall && vppHigh && !lockEff
                && mode == pmvs_pkg::PMVS_PROGRAM_STROBE_CODE) begin
            codeMem[codeAddr] <= p0In;
        end
    end

    // encryption table: written only by programmer, or fixed at build
    always_ff @(posedge mclk) begin
        if (eraseAll) begin
            for (int i = 0; i < `PMVS_ENC_DEPTH; i++) begin
                encMem[i] <= MASK_ROM ? ENC_BUILT : `PMVS_ERASED; // [R8] [R15]
            end
        end else if (!MASK_ROM && strobeFall && vppHigh
                && mode == pmvs_pkg::PMVS_PROGRAM_STROBE_ENC) begin
            encMem[encIdx] <= p0In; // [R15]
        end
    end

    // option byte and lock cells survive reset, cleared by erase only
    always_ff @(posedge mclk) begin
        if (eraseAll) begin
            option_r <= `PMVS_ERASED;
            lock_r <= 1'b0;
        end else if (!MASK_ROM && strobeFall && vppHigh) begin
            if (mode == pmvs_pkg::PMVS_PROGRAM_STROBE_OPT) begin
                option_r <= p0In; // [R1]
            end
            if (mode == pmvs_pkg::PMVS_PROGRAM_STROBE_LOCK) begin
                lock_r <= 1'b1;
            end
        end
    end

    // watchdog default taken from option bit during reset, before execution
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wdtAuto_r <= ~option_r[`PMVS_OPT_WDTOFF]; // [R1] [R2]
        end
    end

    // access pin caught while reset is held, frozen afterwards
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            eaLatch_r <= external_access_pin_n; // [R6]
        end
    end

    // external execution: latched level when locked, live pin otherwise
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            extExec_r <= 1'b0;
        end else begin
            extExec_r <= lockEff ? ~eaLatch_r : ~external_access_pin_n; // [R6]
        end
    end

    // quasi-bidirectional one-shot, one counter per pin
    for (genvar g = 0; g < 8; g++) begin : gShot
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                shotCnt_r[g] <= 2'h0;
                strongN_r[g] <= 1'b1;
            end else if (p1Latch_r[g] && !p1Prev_r[g]) begin
                shotCnt_r[g] <= `PMVS_ONESHOT_CYCLES - 2'h1; // [R12]
                strongN_r[g] <= 1'b0;
            end else if (shotCnt_r[g] != 2'h0) begin
                shotCnt_r[g] <= shotCnt_r[g] - 2'h1;
                strongN_r[g] <= 1'b0;
            end else begin
                strongN_r[g] <= p1Latch_r[g]; // low level stays strong
            end
        end
    end

    // previous port 1 latch for edge detection
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            p1Prev_r <= `PMVS_LATCH_RST;
        end else begin
            p1Prev_r <= p1Latch_r;
        end
    end

    // port 0 drive: reset float, programmer read-out, bus, general i/o
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            p0OeN_r <= 8'hFF; // [R13]
            p0Out_r <= 8'h00;
            p0Weak_r <= 1'b0;
        end else if (mode == pmvs_pkg::PMVS_VERIFY) begin
            p0Out_r <= verifyByte; // [R11] [R16]
            p0OeN_r <= 8'h00;
            p0Weak_r <= 1'b0;
        end else if (mode == pmvs_pkg::PMVS_SIGNATURE) begin
            p0Out_r <= sigByte(pgmAddr); // [R4]
            p0OeN_r <= 8'h00;
            p0Weak_r <= 1'b0;
        end else if (busMode_r) begin
            if (busDrive) begin
                p0Out_r <= busAddrLow;
                p0OeN_r <= 8'h00;
                p0Weak_r <= 1'b0;
            end else begin
                p0OeN_r <= 8'hFF; // keep last level, weak keeper on
                p0Weak_r <= 1'b1; // [R14]
            end
        end else begin
            p0Out_r <= p0Latch_r;
            p0OeN_r <= p0Latch_r; // [R13]
            p0Weak_r <= 1'b0;
        end
    end

    // slave handshake: one wait cycle, then one ready cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(busHit & wait_r);
        end
    end

    // read data: captured in the wait cycle, lock has no readable bit
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && wait_r) begin
            unique case (avs_address)
                `PMVS_OFF_CTRL: rdata_r <= {31'h0, busMode_r};
                `PMVS_OFF_P0LATCH: rdata_r <= {24'h0, p0Latch_r};
                `PMVS_OFF_P1LATCH: rdata_r <= {24'h0, p1Latch_r};
                `PMVS_OFF_TBLADDR: rdata_r <= 32'(tblAddr_r);
                `PMVS_OFF_TBLDATA: rdata_r <= {24'h0, tableBlocked ? `PMVS_BLOCKED_DATA
                        : codeMem[tblAddr_r]}; // [R5]
                `PMVS_OFF_STATUS: rdata_r <= {30'h0, blocked_r, wdtAuto_r}; // [R7]
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // register writes take effect in the ready cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busMode_r <= 1'b0;
            p0Latch_r <= `PMVS_LATCH_RST;
            p1Latch_r <= `PMVS_LATCH_RST;
            tblAddr_r <= '0;
        end else if (avs_write && !wait_r) begin
            if (avs_address == `PMVS_OFF_CTRL) begin
                busMode_r <= avs_writedata[`PMVS_CTRL_BUSMODE];
            end
            if (avs_address == `PMVS_OFF_P0LATCH) begin
                p0Latch_r <= avs_writedata[7:0];
            end
            if (avs_address == `PMVS_OFF_P1LATCH) begin
                p1Latch_r <= avs_writedata[7:0];
            end
            if (avs_address == `PMVS_OFF_TBLADDR) begin
                tblAddr_r <= avs_writedata[ADDR_W-1:0];
            end
        end
    end

    // sticky blocked flag, set by a refused read, cleared by status read
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            blocked_r <= 1'b0;
        end else if (avs_read && wait_r && tableBlocked
                && avs_address == `PMVS_OFF_TBLDATA) begin
            blocked_r <= 1'b1; // [R5]
        end else if (avs_read && !wait_r && avs_address == `PMVS_OFF_STATUS) begin
            blocked_r <= 1'b0;
        end
    end

    // outputs straight from flip-flops
    assign p0Out = p0Out_r;
    assign p0OeN = p0OeN_r;
    assign p0WeakHold = p0Weak_r;
    // level follows the latch one cycle late, in step with the strong enable,
    // so a rising pin is driven hard for exactly the one-shot length
    assign p1Drive.level = p1Prev_r; // [R12]
    assign p1Drive.strongEnN = strongN_r;
    assign wdtAutoEnable = wdtAuto_r;
    assign execExternal = extExec_r;
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;

    // checks
    a_wdt_default: assert property (@(posedge mclk) $rose(reset_n)
            |-> wdtAuto_r == ~option_r[`PMVS_OPT_WDTOFF]) // [R2]
        else $error("watchdog default does not follow option bit");
    a_verify_xnor: assert property (@(posedge mclk) disable iff (!reset_n)
            mode == pmvs_pkg::PMVS_VERIFY |=> p0Out_r == $past(verifyByte)
            && p0OeN_r == 8'h00) // [R9]
        else $error("verify byte not driven on port 0");
    a_sig_model: assert property (@(posedge mclk) disable iff (!reset_n)
            mode == pmvs_pkg::PMVS_SIGNATURE && pgmAddr == `PMVS_SIG_ADDR_MODEL
            |=> p0Out_r == SIG_MODEL) // [R4]
        else $error("model byte wrong");
    a_reset_float: assert property (@(posedge mclk)
            $fell(reset_n) |=> p0OeN_r == 8'hFF) // [R13]
        else $error("port 0 driven during reset");
    a_oneshot_len: assert property (@(posedge mclk) disable iff (!reset_n)
            $rose(p1Latch_r[0]) && $past(reset_n) |=> !strongN_r[0] [*2]
            ##1 (strongN_r[0] || !p1Latch_r[0] || $rose(p1Latch_r[0]))) // [R12]
        else $error("one-shot length wrong");
    a_ea_frozen: assert property (@(posedge mclk) disable iff (!reset_n)
            lockEff && $past(reset_n) |-> $stable(eaLatch_r)) // [R6]
        else $error("access latch changed outside reset");
    a_table_block: assert property (@(posedge mclk) disable iff (!reset_n)
            avs_read && wait_r && tableBlocked && avs_address == `PMVS_OFF_TBLDATA
            |=> rdata_r == {24'h0, `PMVS_BLOCKED_DATA} ##1 blocked_r) // [R5]
        else $error("locked table read not refused");
    a_bus_hold: assert property (@(posedge mclk) disable iff (!reset_n)
            busMode_r && !busDrive && mode == pmvs_pkg::PMVS_IDLE
            |=> p0Weak_r && $stable(p0Out_r)) // [R14]
        else $error("port 0 keeper lost address");
    a_slave_ready: assert property (@(posedge mclk) disable iff (!reset_n)
            busHit && wait_r |=> !wait_r ##1 wait_r)
        else $error("bus answer timing wrong");

endmodule : pmvs_core

// *** test/pmvs_program_strobe_model.sv ***
// device programmer fixture that drives the programming pins of the block
module pmvs_program_strobe_model (
    input wire logic mclk,
    input wire logic [7:0] p0Out,
    output logic pgmEnable,
    output logic vppHigh,
    output pmvs_pkg::pmvs_ctl_s pgmCtl,
    output logic program_strobe_n,
    output logic [15:0] pgmAddr,
    output logic [7:0] p0In
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0; // fixture drives port 0
    logic [7:0] dat = 8'h00; // byte offered on port 0
    logic [7:0] junk = 8'h5A; // pattern on a released port 0

    // a released port 0 flips every cycle so no stale value can pass
    always @(posedge mclk) begin
        junk <= ~junk;
    end
    assign p0In = drv ? dat : junk;

    // pins idle at time zero
    initial begin
        pgmEnable = 1'b0;
        vppHigh = 1'b0;
        pgmCtl = 5'b10000;
        program_strobe_n = 1'b1;
        pgmAddr = 16'h0000;
    end

    // levels, address and data first, then the strobe train
    task write_cell(input logic [4:0] ctl, input logic [15:0] a, input logic [7:0] d);
        pgmEnable <= 1'b1;
        vppHigh <= 1'b1;
        pgmCtl <= ctl;
        pgmAddr <= a;
        drv <= 1'b1;
        dat <= (ctl == 5'b01100) ? (d | 8'hF7) : d;
        @(posedge mclk);
        repeat ((ctl == 5'b01111) ? 5 : 25) begin
            program_strobe_n <= 1'b0;
            @(posedge mclk);
            program_strobe_n <= 1'b1;
            @(posedge mclk);
        end
        vppHigh <= 1'b0;
        drv <= 1'b0;
        pgmCtl <= 5'b10000;
        @(posedge mclk);
    endtask : write_cell

    // read-out: address and levels set, byte taken off port 0
    task read_cell(input logic [4:0] ctl, input logic [15:0] a, output logic [7:0] d);
        pgmEnable <= 1'b1;
        pgmCtl <= ctl;
        pgmAddr <= a;
        repeat (3) @(posedge mclk);
        d = p0Out;
        pgmCtl <= 5'b10000;
        @(posedge mclk);
    endtask : read_cell

    // leave programming mode
    task leave;
        pgmEnable <= 1'b0;
        @(posedge mclk);
    endtask : leave
endmodule : pmvs_program_strobe_model

// *** test/testbench.sv ***
// self-checking bench of the program memory access block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, reset_n = 1'b0, eraseAll = 1'b1, pgmEnable, vppHigh, program_strobe_n;
    pmvs_pkg::pmvs_ctl_s pgmCtl; // programmer control levels
    pmvs_pkg::pmvs_quasi_s p1Drive; // port 1 drive
    logic [15:0] pgmAddr, adr [4];
    logic [7:0] p0In, p0Out, p0OeN, busAddrLow = 8'h00, rd8, code [4], tbl [64];
    logic p0WeakHold, external_access_pin_n = 1'b1, fetchExternal = 1'b0, busDrive = 1'b0;
    logic wdtAutoEnable, execExternal, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    int error_cnt = 0, num_checks = 0, cyc = 0, osCnt = 0;
    localparam logic [15:0] SIG_A [4] = '{16'h0030, 16'h0031, 16'h0060, 16'h0061};
    localparam logic [7:0] SIG_V [4] = '{8'hA5, 8'h96, 8'h4B, 8'h00}; // arbitrary identity values

    pmvs_core #(.SIG_MFR(8'hA5), .SIG_MODEL(8'h96), .SIG_EXT(8'h4B)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .eraseAll(eraseAll), .pgmEnable(pgmEnable),
        .vppHigh(vppHigh), .pgmCtl(pgmCtl), .program_strobe_n(program_strobe_n),
        .pgmAddr(pgmAddr), .p0In(p0In), .p0Out(p0Out), .p0OeN(p0OeN), .p0WeakHold(p0WeakHold),
        .external_access_pin_n(external_access_pin_n), .fetchExternal(fetchExternal),
        .busDrive(busDrive), .busAddrLow(busAddrLow), .p1Drive(p1Drive),
        .wdtAutoEnable(wdtAutoEnable), .execExternal(execExternal), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    pmvs_program_strobe_model program_strobe_u (.mclk(mclk), .p0Out(p0Out), .pgmEnable(pgmEnable),
        .vppHigh(vppHigh), .pgmCtl(pgmCtl), .program_strobe_n(program_strobe_n),
        .pgmAddr(pgmAddr), .p0In(p0In));

    // 25 MHz clock
    initial begin
        forever #20 mclk = ~mclk;
    end

    // hang guard and one-shot cycle counter
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (p1Drive.level === 8'hFF && p1Drive.strongEnN === 8'h00) begin
            osCnt <= osCnt + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // expected verify byte
    function automatic logic [7:0] xnor8(input logic [7:0] a, input logic [7:0] b);
        return ~(a ^ b);
    endfunction : xnor8

    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one slave access, held until waitrequest is seen low
    task av(input logic w, input logic [7:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= ~w;
        // the hang guard ends this wait if waitrequest never goes low
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : av

    // five cycles of reset
    task rst;
        reset_n <= 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask : rst

    // verdict
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // main sequence
    initial begin
        void'($urandom(32'h8ffe2bbf));
        foreach (tbl[k]) tbl[k] = 8'hFF;
        adr = '{16'h0000, 16'h0040, 16'h3FFF, {4'h1, 12'($urandom)}};
        repeat (5) @(posedge mclk);
        chk(p0OeN, 8'hFF);
        eraseAll <= 1'b0;
        reset_n <= 1'b1;
        @(posedge mclk);
        chk(wdtAutoEnable, 1'b0);
        av(1'b0, 8'h04, 32'h0);
        chk(rd, 32'hFF);
        av(1'b0, 8'h08, 32'h0);
        chk(rd, 32'hFF);
        av(1'b1, 8'h20, 32'h1);
        av(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        // unlocked: execution follows the live pin
        external_access_pin_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(execExternal, 1'b1);
        external_access_pin_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(execExternal, 1'b0);
        // code bytes, erased table passes them through
        for (int i = 0; i < 4; i++) begin
            code[i] = 8'($urandom);
            program_strobe_u.write_cell(5'b01111, adr[i], code[i]);
        end
        for (int i = 0; i < 4; i++) begin
            program_strobe_u.read_cell(5'b00011, adr[i], rd8);
            chk(rd8, code[i]);
        end
        // table bytes; addresses 0000 and 0040 share one entry
        for (int i = 0; i < 4; i++) begin
            tbl[adr[i][5:0]] = 8'($urandom);
            program_strobe_u.write_cell(5'b01101, adr[i], tbl[adr[i][5:0]]);
        end
        for (int i = 0; i < 4; i++) begin
            program_strobe_u.read_cell(5'b00011, adr[i], rd8);
            chk(rd8, xnor8(code[i], tbl[adr[i][5:0]]));
        end
        for (int i = 0; i < 4; i++) begin
            program_strobe_u.read_cell(5'b00000, SIG_A[i], rd8);
            chk(rd8, SIG_V[i]);
        end
        program_strobe_u.leave();
        // unlocked external table read sees the code
        fetchExternal <= 1'b1;
        av(1'b1, 8'h0C, {16'h0, adr[3]});
        av(1'b0, 8'h10, 32'h0);
        chk(rd, {24'h0, code[3]});
        // port 0 drives only where its latch is low
        av(1'b1, 8'h04, 32'h3C);
        repeat (2) @(posedge mclk);
        chk(p0OeN, 8'h3C);
        // bus mode keeper holds the last address
        av(1'b1, 8'h00, 32'h1);
        busAddrLow <= 8'($urandom);
        busDrive <= 1'b1;
        repeat (2) @(posedge mclk);
        busDrive <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({p0WeakHold, p0OeN, p0Out}, {1'b1, 8'hFF, busAddrLow});
        av(1'b1, 8'h00, 32'h0);
        // one-shot on a rising port 1 latch
        av(1'b1, 8'h08, 32'h0);
        osCnt = 0;
        av(1'b1, 8'h08, 32'hFF);
        repeat (6) @(posedge mclk);
        chk(osCnt, 2);
        // option bit 3 cleared, lock set, later code write refused
        program_strobe_u.write_cell(5'b01100, 16'h00FC, 8'h00);
        program_strobe_u.write_cell(5'b11111, 16'h0000, 8'h00);
        program_strobe_u.write_cell(5'b01111, adr[0], ~code[0]);
        program_strobe_u.read_cell(5'b00011, adr[0], rd8);
        chk(rd8, xnor8(code[0], tbl[adr[0][5:0]]));
        program_strobe_u.leave();
        external_access_pin_n <= 1'b0;
        rst();
        external_access_pin_n <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(execExternal, 1'b1);
        chk(wdtAutoEnable, 1'b1);
        av(1'b0, 8'h10, 32'h0);
        chk(rd, 32'hFF);
        av(1'b0, 8'h14, 32'h0);
        chk(rd[1:0], 2'b11);
        av(1'b0, 8'h14, 32'h0);
        chk(rd[1], 1'b0);
        fetchExternal <= 1'b0;
        av(1'b0, 8'h10, 32'h0);
        chk(rd, {24'h0, code[0]});
        wrap_up();
    end
endmodule : testbench
